//--- core/rz_stripe_manager.sv
// Purpose: Two-way striping between a wide user stream and two controllers
// Assumes: Controllers share clk; their command and data ports as below
// Notes:   Stream lengths and addresses are in 512-byte stripes
`timescale 1ns/100ps
`default_nettype none
module rz_stripe_manager
  import rz_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                usr_wr_valid,
  output logic                     usr_wr_ready,
  input  wire logic [USER_DW-1:0]  usr_wr_data,
  output logic                     write_fifo_almost_full,
  output logic                     usr_rd_valid,
  input  wire logic                usr_rd_ready,
  output logic [USER_DW-1:0]       usr_rd_data,
  input  wire logic                cpu_req,
  input  wire rz_cmd_s             cpu_cmd,
  output logic                     cpu_busy,
  output logic                     cpu_done,
  output logic                     cpu_error,
  output logic [NCH-1:0]           ctl_req,
  output rz_cmd_s [NCH-1:0]        ctl_cmd,
  input  wire logic [NCH-1:0]      ctl_ack,
  input  wire logic [NCH-1:0]      ctl_busy,
  input  wire logic [NCH-1:0]      ctl_error,
  output logic [NCH-1:0]           ctl_wr_valid,
  input  wire logic [NCH-1:0]      ctl_wr_ready,
  output logic [CTL_DW-1:0]        ctl_wr_data,
  input  wire logic [NCH-1:0]      ctl_rd_valid,
  output logic [NCH-1:0]           ctl_rd_ready,
  input  wire logic [NCH-1:0][CTL_DW-1:0] ctl_rd_data,
  input  wire rz_ram_s [NCH-1:0]   ctl_ram,
  output rz_ram_s [NCH-1:0]        cpu_ram
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_GAP,
    ST_WRITE,
    ST_READ,
    ST_WAIT
  } rz_state_e;

  typedef struct packed {
    rz_state_e            st;
    rz_op_e               op;
    logic                 ch;
    logic [BEAT_W-1:0]    beat;
    logic [OVH_W-1:0]     ovh;
    logic [LEN_W-1:0]     left;
    logic [NCH-1:0]       req;
    rz_cmd_s [NCH-1:0]    cmd;
    rz_ram_s [NCH-1:0]    ram;
    logic                 have;
    logic                 half;
    logic [CTL_DW-1:0]    wd;
    logic [CTL_DW-1:0]    hi;
    logic [CTL_DW-1:0]    low;
    logic                 done;
    logic                 err;
  } rz_sm_state_s;

  rz_sm_state_s         s_r;
  rz_sm_state_s         s_nxt;
  logic                 wf_valid;
  logic                 wf_pop;
  logic [USER_DW-1:0]   wf_data;
  logic                 rf_ready;
  logic                 rf_push;
  logic [USER_DW-1:0]   rf_data;
  logic [NCH-1:0]       rd_ready;
  logic                 beat_done;
  logic [LEN_W-1:0]     len_even;
  logic [LEN_W-1:0]     len_odd;

  // Write path: user pushes, manager drains
  rz_fifo
  #(
    .W     (USER_DW),
    .DEPTH (FIFO_DEPTH),
    .AFULL (FIFO_AFULL)
  )
  user_to_core_fifo
  (
    .clk         (clk),
    .reset       (reset),
    .in_valid    (usr_wr_valid),
    .in_ready    (usr_wr_ready),
    .in_data     (usr_wr_data),
    .out_valid   (wf_valid),
    .out_ready   (wf_pop),
    .out_data    (wf_data),
    .almost_full (write_fifo_almost_full)
  );

  // Read path: manager pushes, user drains
  rz_fifo
  #(
    .W     (USER_DW),
    .DEPTH (FIFO_DEPTH),
    .AFULL (FIFO_AFULL)
  )
  core_to_user_fifo
  (
    .clk         (clk),
    .reset       (reset),
    .in_valid    (rf_push),
    .in_ready    (rf_ready),
    .in_data     (rf_data),
    .out_valid   (usr_rd_valid),
    .out_ready   (usr_rd_ready),
    .out_data    (usr_rd_data),
    .almost_full ()
  );

  // Drive zero takes the odd stripe out
  assign len_even = LEN_W'(({1'b0, cpu_cmd.len} + 33'h1) >> 1);
  assign len_odd  = cpu_cmd.len >> 1;

  always_comb
  begin
    s_nxt     = s_r;
    wf_pop    = 1'b0;
    rf_push   = 1'b0;
    rf_data   = {ctl_rd_data[s_r.ch], s_r.low};
    rd_ready  = '0;
    beat_done = 1'b0;
    s_nxt.done = 1'b0;

    // Non-stream data bypasses the FIFOs into CPU RAM
    for (int i = 0; i < NCH; i++)
    begin
      s_nxt.ram[i].we = 1'b0;
      if (ctl_ram[i].we && !rz_is_stream(s_r.op) &&
          (s_r.st == ST_ISSUE || s_r.st == ST_WAIT))
      begin
        s_nxt.ram[i] = ctl_ram[i];
      end
    end

    if (s_r.st != ST_IDLE && ctl_error != '0)
    begin
      s_nxt.err = 1'b1;
    end

    case (s_r.st)
      ST_IDLE:
      begin
        if (cpu_req)
        begin
          // One request fans out to each controller that has work for it
          s_nxt.op   = cpu_cmd.op;
          s_nxt.left = cpu_cmd.len;
          s_nxt.ch   = 1'b0;
          s_nxt.beat = '0;
          s_nxt.half = 1'b0;
          s_nxt.err  = 1'b0;
          s_nxt.req  = {1'b1, 1'b1};
          for (int i = 0; i < NCH; i++)
          begin
            s_nxt.cmd[i] = cpu_cmd;
          end
          if (rz_is_stream(cpu_cmd.op))
          begin
            // Both drives start at half the logical stripe address
            s_nxt.cmd[0].addr = cpu_cmd.addr >> 1;
            s_nxt.cmd[1].addr = cpu_cmd.addr >> 1;
            s_nxt.cmd[0].len  = len_even;
            s_nxt.cmd[1].len  = len_odd;
            s_nxt.req[1]      = len_odd != '0;
            s_nxt.req[0]      = len_even != '0;
          end
          s_nxt.st = ST_ISSUE;
        end
      end

      ST_ISSUE:
      begin
        s_nxt.req = s_r.req & ~ctl_ack;
        s_nxt.ovh = '0;
        if ((s_r.req & ~ctl_ack) == '0)
        begin
          if (rz_is_stream(s_r.op) && s_r.left != '0)
          begin
            s_nxt.st = ST_GAP;
          end
          else
          begin
            s_nxt.st = ST_WAIT;
          end
        end
      end

      ST_GAP:
      begin
        // Idle time before each block; costs 1/8 of the stripe
        s_nxt.ovh = s_r.ovh + OVH_W'(1);
        if (s_r.ovh == OVH_W'(OVH_CYCLES - 1))
        begin
          s_nxt.ovh = '0;
          s_nxt.st  = (s_r.op == RZ_OP_WRITE) ? ST_WRITE : ST_READ;
        end
      end

      ST_WRITE:
      begin
        // Low half first, then high half of each user word
        if (s_r.have && ctl_wr_ready[s_r.ch])
        begin
          beat_done  = 1'b1;
          s_nxt.wd   = s_r.hi;
          s_nxt.half = ~s_r.half;
          if (s_r.half)
          begin
            s_nxt.have = 1'b0;
          end
        end
        // Refill in the same cycle the high half leaves, to keep pace
        if (wf_valid && (!s_r.have || (s_r.half && ctl_wr_ready[s_r.ch])))
        begin
          wf_pop     = 1'b1;
          s_nxt.wd   = wf_data[CTL_DW-1:0];
          s_nxt.hi   = wf_data[USER_DW-1:CTL_DW];
          s_nxt.have = 1'b1;
          s_nxt.half = 1'b0;
        end
      end

      ST_READ:
      begin
        // High half is held off until the read FIFO has room
        rd_ready[s_r.ch] = !s_r.half || rf_ready;
        if (ctl_rd_valid[s_r.ch] && rd_ready[s_r.ch])
        begin
          beat_done  = 1'b1;
          s_nxt.half = ~s_r.half;
          if (!s_r.half)
          begin
            s_nxt.low = ctl_rd_data[s_r.ch];
          end
          else
          begin
            rf_push = 1'b1;
          end
        end
      end

      ST_WAIT:
      begin
        if (ctl_busy == '0)
        begin
          s_nxt.done = 1'b1;
          s_nxt.st   = ST_IDLE;
        end
      end

      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (beat_done)
    begin
      s_nxt.beat = s_r.beat + BEAT_W'(1);
      // Whole stripe with one drive, then hand over
      if (s_r.beat == BEAT_W'(STRIPE_BEATS - 1))
      begin
        s_nxt.beat = '0;
        s_nxt.ch   = ~s_r.ch;
        s_nxt.left = s_r.left - LEN_W'(1);
        s_nxt.st   = (s_r.left == LEN_W'(1)) ? ST_WAIT : ST_GAP;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign cpu_busy     = s_r.st != ST_IDLE;
  assign cpu_done     = s_r.done;
  assign cpu_error    = s_r.err;
  assign ctl_req      = s_r.req;
  assign ctl_cmd      = s_r.cmd;
  assign cpu_ram      = s_r.ram;
  assign ctl_rd_ready = rd_ready;
  // Controller beat is the link's 256-bit word
  assign ctl_wr_data  = s_r.wd;

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_wr_valid
      assign ctl_wr_valid[g] = (s_r.st == ST_WRITE) && s_r.have && (s_r.ch == 1'(g));
    end
  endgenerate

endmodule : rz_stripe_manager
`default_nettype wire

//--- shared/rz_pkg.sv
// Purpose: Shared constants and types for the two-way striping layer
// Assumes: One user clock; controllers and FIFOs run on it
// Notes:   Lengths and addresses count 512-byte stripes
package rz_pkg;

  localparam int NCH          = 2;
  localparam int USER_DW      = 512;
  localparam int CTL_DW       = USER_DW / 2;
  localparam int STRIPE_BYTES = 512;
  localparam int STRIPE_BEATS = STRIPE_BYTES / (CTL_DW / 8);
  localparam int BEAT_W       = $clog2(STRIPE_BEATS);
  localparam int OVH_CYCLES   = STRIPE_BEATS / 8;
  localparam int OVH_W        = $clog2(OVH_CYCLES + 1);
  localparam int ADDR_W       = 48;
  localparam int LEN_W        = 32;
  localparam int RAM_AW       = 9;
  localparam int FIFO_DEPTH   = 8;
  localparam int FIFO_AFULL   = 6;

  // Link clock and the least user clock it implies
  localparam int LINK_CLK_KHZ     = 250000;
  localparam int MIN_USER_CLK_KHZ = LINK_CLK_KHZ * (8 + 1) / 8;

  typedef enum logic [2:0] {
    RZ_OP_IDENTIFY,
    RZ_OP_WRITE,
    RZ_OP_READ,
    RZ_OP_SMART,
    RZ_OP_FLUSH,
    RZ_OP_ERASE,
    RZ_OP_SHUTDOWN
  } rz_op_e;

  typedef struct packed {
    rz_op_e              op;
    logic [ADDR_W-1:0]   addr;
    logic [LEN_W-1:0]    len;
  } rz_cmd_s;

  typedef struct packed {
    logic                we;
    logic [RAM_AW-1:0]   addr;
    logic [CTL_DW-1:0]   data;
  } rz_ram_s;

  function automatic logic rz_is_stream(input rz_op_e op);
    rz_is_stream = (op == RZ_OP_WRITE) || (op == RZ_OP_READ);
  endfunction : rz_is_stream

endpackage : rz_pkg

//--- core/rz_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Almost-full lets a source with pipeline slack stop early
`timescale 1ns/100ps
`default_nettype none
module rz_fifo
#(
  parameter int W     = 512,
  parameter int DEPTH = 8,
  parameter int AFULL = 6
)
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              almost_full
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } rz_fifo_state_s;

  rz_fifo_state_s s_r;
  rz_fifo_state_s s_nxt;
  logic [W-1:0]   mem [DEPTH];
  logic           push;
  logic           pop;

  assign in_ready    = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid   = s_r.cnt != '0;
  assign almost_full = s_r.cnt >= (AW+1)'(AFULL);
  assign out_data    = mem[s_r.rp];
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (pop)
    begin
      s_nxt.rp = s_r.rp + AW'(1);
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Storage is not reset; only pointers qualify it
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[s_r.wp] <= in_data;
    end
  end

endmodule : rz_fifo
`default_nettype wire

//--- tb/rz_stripe_manager_assertions.sv
// Purpose: Port checker for the striping layer
// Assumes: One clock, sync reset
// Notes:   Beat counter restarts at every taken command
`timescale 1ns/100ps
`default_nettype none
module rz_sm_assertions
  import rz_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              cpu_req,
  input wire logic              cpu_busy,
  input wire logic              cpu_done,
  input wire logic [NCH-1:0]    ctl_req,
  input wire rz_cmd_s [NCH-1:0] ctl_cmd,
  input wire logic [NCH-1:0]    ctl_ack,
  input wire logic [NCH-1:0]    ctl_wr_valid,
  input wire logic [NCH-1:0]    ctl_wr_ready,
  input wire rz_ram_s [NCH-1:0] ctl_ram,
  input wire rz_ram_s [NCH-1:0] cpu_ram
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0] cnt_r;
  logic       last_r;
  wire        hs = |(ctl_wr_valid & ctl_wr_ready);
  wire        strm = ctl_cmd[0].op == RZ_OP_WRITE || ctl_cmd[0].op == RZ_OP_READ;
  always_ff @(posedge clk)
  begin
    if (reset || (cpu_req && !cpu_busy))
    begin
      cnt_r  <= 5'h0;
      last_r <= 1'b0;
    end
    else if (hs)
    begin
      cnt_r  <= (ctl_wr_valid[1] != last_r) ? 5'h1 : cnt_r + 5'h1;
      last_r <= ctl_wr_valid[1];
    end
  end
  AST_TAKE_BUSY: assert property (cpu_req && !cpu_busy |=> cpu_busy)
    else $error("busy missing after take");
  AST_DONE_PULSE: assert property (cpu_done |-> !cpu_busy ##1 !cpu_done)
    else $error("done not a lone pulse");
  AST_REQ_HOLD: assert property (ctl_req[0] && !ctl_ack[0] |=> ctl_req[0])
    else $error("request dropped early");
  AST_REQ_DROP: assert property (ctl_req[1] && ctl_ack[1] |=> !ctl_req[1])
    else $error("request kept after ack");
  AST_ONE_CH: assert property ($onehot0(ctl_wr_valid))
    else $error("both channels valid");
  AST_SWITCH: assert property (hs && ctl_wr_valid[1] != last_r |-> cnt_r == STRIPE_BEATS)
    else $error("switch off a stripe edge");
  AST_GAP: assert property (hs && cnt_r == STRIPE_BEATS - 1 |=> (ctl_wr_valid == 2'h0)[*2])
    else $error("stripe gap too short");
  AST_RAM_COPY: assert property (cpu_busy && !strm && ctl_ram[0].we |=>
    cpu_ram[0].we && cpu_ram[0].data == $past(ctl_ram[0].data) && cpu_ram[0].addr == $past(ctl_ram[0].addr))
    else $error("ram word not copied");
  AST_NO_RAM: assert property (cpu_busy && strm |=> !cpu_ram[0].we && !cpu_ram[1].we)
    else $error("ram written in stream");
endmodule : rz_sm_assertions
bind rz_stripe_manager rz_sm_assertions i_chk (.clk(clk), .reset(reset), .cpu_req(cpu_req),
  .cpu_busy(cpu_busy), .cpu_done(cpu_done), .ctl_req(ctl_req), .ctl_cmd(ctl_cmd), .ctl_ack(ctl_ack),
  .ctl_wr_valid(ctl_wr_valid), .ctl_wr_ready(ctl_wr_ready), .ctl_ram(ctl_ram), .cpu_ram(cpu_ram));
`default_nettype wire

//--- tb/rz_ctl_model.sv
// Purpose: Two drive controllers seen from the striping layer
// Assumes: Busy rises with ack; random ack delay and write stalls
// Notes:   Beat data is channel and beat index; idle data is noise
`timescale 1ns/100ps
`default_nettype none
module rz_ctl_model
  import rz_pkg::*;
(
  input  wire logic [NCH-1:0]        clk,
  input  wire logic                  reset,
  input  wire logic [NCH-1:0]        ctl_req,
  input  wire rz_cmd_s [NCH-1:0]     ctl_cmd,
  output logic [NCH-1:0]             ctl_ack,
  output logic [NCH-1:0]             ctl_busy,
  input  wire logic [NCH-1:0]        ctl_wr_valid,
  output logic [NCH-1:0]             ctl_wr_ready,
  output logic [NCH-1:0]             ctl_rd_valid,
  input  wire logic [NCH-1:0]        ctl_rd_ready,
  output logic [NCH-1:0][CTL_DW-1:0] ctl_rd_data,
  output rz_ram_s [NCH-1:0]          ctl_ram
);
  int                         seed = 32'hF9FE8A1E;
  logic [NCH-1:0][15:0]       rem;
  logic [NCH-1:0][27:0]       idx;
  logic [NCH-1:0]             rd;
  logic [NCH-1:0]             strm;
  logic [NCH-1:0][CTL_DW-1:0] noise;
  always @(posedge clk[0])
    for (int i = 0; i < NCH; i++)
    begin
      noise[i]        <= {8{$random(seed)}};
      ctl_wr_ready[i] <= 1'($random(seed));
      ctl_ram[i]      <= '{!reset && ctl_busy[i] && !strm[i] && rem[i] != 0, rem[i][8:0], {8{$random(seed)}}};
      ctl_ack[i]      <= 1'b0;
      if (reset)
      begin
        ctl_busy[i]   <= 1'b0;
        rem[i]        <= 16'h0;
      end
      else if (ctl_req[i] && !ctl_ack[i] && !ctl_busy[i] && $random(seed) % 3 == 0)
      begin
        ctl_ack[i]  <= 1'b1;
        ctl_busy[i] <= 1'b1;
        strm[i]     <= ctl_cmd[i].op == RZ_OP_WRITE || ctl_cmd[i].op == RZ_OP_READ;
        rd[i]       <= ctl_cmd[i].op == RZ_OP_READ;
        rem[i]      <= (ctl_cmd[i].op == RZ_OP_WRITE || ctl_cmd[i].op == RZ_OP_READ)
                       ? 16'(ctl_cmd[i].len * STRIPE_BEATS) : 16'h4;
        idx[i]      <= 28'h0;
      end
      else if (ctl_busy[i] && rem[i] == 0)
        ctl_busy[i] <= 1'b0;
      else if (ctl_busy[i] && (!strm[i] || (ctl_wr_valid[i] && ctl_wr_ready[i]) || (ctl_rd_valid[i] && ctl_rd_ready[i])))
      begin
        rem[i] <= rem[i] - 16'h1;
        idx[i] <= idx[i] + 28'h1;
      end
    end
  always_comb
    for (int i = 0; i < NCH; i++)
    begin
      ctl_rd_valid[i] = ctl_busy[i] && rd[i] && rem[i] != 0;
      ctl_rd_data[i]  = ctl_rd_valid[i] ? {8{4'(i), idx[i]}} : noise[i];
    end
endmodule : rz_ctl_model
`default_nettype wire

//--- tb/test_rz_stripe_manager.sv
// Purpose: Self-checking bench for the two-way striping layer
// Assumes: Bench is user logic and CPU; model stands for the drives
// Notes:   Drivers queue expected words; a monitor pops and compares
`timescale 1ns/100ps
`default_nettype none
module test_rz_stripe_manager
  import rz_pkg::*;
  ;
  logic clk = 1'b0, reset = 1'b1, usr_wr_valid = 1'b0, usr_rd_ready = 1'b0, cpu_req = 1'b0, rd_hold = 1'b0;
  logic usr_wr_ready, write_fifo_almost_full, usr_rd_valid, cpu_busy, cpu_done, cpu_error;
  logic [USER_DW-1:0] usr_wr_data = '0, usr_rd_data;
  rz_cmd_s cpu_cmd = '0;
  logic [NCH-1:0] ctl_req, ctl_ack, ctl_busy, ctl_wr_valid, ctl_wr_ready, ctl_rd_valid, ctl_rd_ready;
  logic [NCH-1:0] ctl_error = '0;
  rz_cmd_s [NCH-1:0] ctl_cmd;
  logic [CTL_DW-1:0] ctl_wr_data;
  logic [NCH-1:0][CTL_DW-1:0] ctl_rd_data;
  rz_ram_s [NCH-1:0] ctl_ram;
  int seed = 32'hF9FE8A1E, num_errors = 0, compares = 0;
  logic [CTL_DW:0] exp_wr[$];
  logic [USER_DW-1:0] exp_rd[$];
  rz_op_e nops[5] = '{RZ_OP_IDENTIFY, RZ_OP_SMART, RZ_OP_FLUSH, RZ_OP_ERASE, RZ_OP_SHUTDOWN};
  always #50 clk = ~clk;
  rz_stripe_manager i_dut (.clk, .reset, .usr_wr_valid, .usr_wr_ready, .usr_wr_data, .write_fifo_almost_full,
    .usr_rd_valid, .usr_rd_ready, .usr_rd_data, .cpu_req, .cpu_cmd, .cpu_busy, .cpu_done, .cpu_error, .ctl_req,
    .ctl_cmd, .ctl_ack, .ctl_busy, .ctl_error, .ctl_wr_valid, .ctl_wr_ready, .ctl_wr_data, .ctl_rd_valid,
    .ctl_rd_ready, .ctl_rd_data, .ctl_ram, .cpu_ram());
  rz_ctl_model i_model (.clk({clk, clk}), .reset, .ctl_req, .ctl_cmd, .ctl_ack, .ctl_busy, .ctl_wr_valid,
    .ctl_wr_ready, .ctl_rd_valid, .ctl_rd_ready, .ctl_rd_data, .ctl_ram);
  task automatic check(input string nm, input logic [USER_DW:0] e, input logic [USER_DW:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic results();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  function automatic logic [USER_DW-1:0] rnd();
    logic [USER_DW-1:0] w;
    for (int j = 0; j < 16; j++)
      w[j*32 +: 32] = $random(seed);
    return w;
  endfunction : rnd
  function automatic logic [CTL_DW-1:0] beat(input int ch, input int ix);
    return {8{4'(ch), 28'(ix)}};
  endfunction : beat
  task automatic push(input int base, input int n, input bit obey);
    logic [USER_DW-1:0] w;
    logic nv;
    int k;
    k = 0;
    w = rnd();
    while (k < n)
    begin
      @(negedge clk);
      nv = usr_wr_valid;
      if (usr_wr_valid && usr_wr_ready)
      begin
        exp_wr.push_back({1'(((base + k) / 8) % 2), w[CTL_DW-1:0]});
        exp_wr.push_back({1'(((base + k) / 8) % 2), w[USER_DW-1:CTL_DW]});
        k++;
        w = rnd();
        nv = 1'b0;
      end
      if (!nv)
        nv = k < n && !(obey && write_fifo_almost_full);
      @(posedge clk);
      usr_wr_valid <= nv;
      usr_wr_data <= w;
    end
  endtask : push
  task automatic run_cmd(input rz_op_e op, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n);
    rz_cmd_s e0, e1;
    int t;
    e0 = '{op, a, n};
    e1 = e0;
    if (op == RZ_OP_WRITE || op == RZ_OP_READ)
    begin
      e0 = '{op, a >> 1, (n + 1) >> 1};
      e1 = '{op, a >> 1, n >> 1};
    end
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_cmd <= '{op, a, n};
    @(posedge clk);
    cpu_req <= 1'b0;
    @(negedge clk);
    check("cpu_busy", 1, cpu_busy);
    check("ctl_req", {e1.len != 0, 1'b1}, ctl_req);
    check("ctl_cmd0", e0, ctl_cmd[0]);
    if (e1.len != 0)
      check("ctl_cmd1", e1, ctl_cmd[1]);
    for (t = 0; t < 3000 && cpu_done !== 1'b1; t++)
      @(negedge clk);
    check("cpu_done", 1, cpu_done);
  endtask : run_cmd
  always @(posedge clk)
    usr_rd_ready <= !rd_hold;
  always @(negedge clk)
  begin
    if (!reset && |(ctl_wr_valid & ctl_wr_ready))
      check("ctl_wr", exp_wr.pop_front(), {ctl_wr_valid[1], ctl_wr_data});
    if (!reset && usr_rd_valid && usr_rd_ready)
      check("usr_rd", exp_rd.pop_front(), usr_rd_data);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("usr_wr_ready", 1, usr_wr_ready);
    check("ctl_req", 0, ctl_req);
    // Controllers share clk here, so the least user clock is only a constant
    check("min_user_clk", 281250, MIN_USER_CLK_KHZ);
    $display("test reset done");
    push(0, 8, 1'b0);
    @(negedge clk);
    check("almost_full", 1, write_fifo_almost_full);
    check("usr_wr_ready", 0, usr_wr_ready);
    fork
      run_cmd(RZ_OP_WRITE, 48'h4, 32'h2);
      push(8, 8, 1'b1);
    join
    fork
      run_cmd(RZ_OP_WRITE, 48'h8, 32'h3);
      push(0, 24, 1'b1);
    join
    check("wr_left", 0, exp_wr.size());
    $display("test write done");
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 8; k++)
        exp_rd.push_back({beat(s % 2, (s / 2) * 16 + 2 * k + 1), beat(s % 2, (s / 2) * 16 + 2 * k)});
    rd_hold = 1'b1;
    fork
      run_cmd(RZ_OP_READ, 48'h6, 32'h3);
      begin
        repeat (100) @(negedge clk);
        check("usr_rd_valid", 1, usr_rd_valid);
        check("ctl_rd_ready", 0, ctl_rd_ready);
        rd_hold = 1'b0;
      end
    join
    for (int t = 0; t < 200 && exp_rd.size() != 0; t++)
      @(negedge clk);
    check("rd_left", 0, exp_rd.size());
    $display("test read done");
    foreach (nops[j])
    begin
      // One controller error mid-command; flag must stand until the next take
      fork
        run_cmd(nops[j], 48'h10, 32'h5);
        if (j == 2)
        begin
          repeat (4) @(posedge clk);
          ctl_error <= 2'h2;
          @(posedge clk);
          ctl_error <= 2'h0;
        end
      join
      check("usr_rd_valid", 0, usr_rd_valid);
      check("cpu_error", j == 2, cpu_error);
    end
    $display("test commands done");
    results();
  end
endmodule : test_rz_stripe_manager
`default_nettype wire
